/* File: src/vectored_irq_unit.sv */
// Vectored, prioritised, maskable interrupt controller
// Contract
// - Eight programmable priority levels resolve simultaneous normal-request sources.
// - Every source has its own mask bit blocking only that source.
// - Two request outputs drive the core: fast and normal.
// - Only the external fast-request pin drives the fast request output.
// - Peripheral sources and external lines 0 to 3 drive the normal request.
// - Each internal source is level sensitive or edge triggered by setting.
// - Each external line: positive edge, negative edge, high or low level.
`timescale 1ns/1ns
`default_nettype none
module vectored_irq_unit
    import vectored_irq_pkg::*;
#(
    parameter int N_INT = NUM_INT_SRC
)
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [N_INT-1:0] periph_src_in,
    input wire logic [NUM_EXT_SRC-1:0] ext_request_line_in,
    input wire logic ext_fast_request_in,
    input wire logic fast_enable_in,
    input wire logic [N_INT-1:0] int_edge_mode_in,
    input wire logic [2*NUM_EXT_SRC-1:0] ext_mode_in,
    input wire logic [N_INT+NUM_EXT_SRC-1:0] src_enable_in,
    input wire logic [PRIO_W*(N_INT+NUM_EXT_SRC)-1:0] src_prio_in,
    input wire logic [VEC_W*(N_INT+NUM_EXT_SRC)-1:0] src_vector_in,
    input wire logic [N_INT+NUM_EXT_SRC-1:0] edge_clear_in,
    output logic core_fast_request_out,
    output logic core_normal_request_out,
    output logic [VEC_W-1:0] handler_vector_out,
    output logic [PRIO_W-1:0] active_prio_out,
    output logic [N_INT+NUM_EXT_SRC-1:0] pending_out
);
    localparam int NS = N_INT + NUM_EXT_SRC;

    logic [NS-1:0] raw_r;
    logic [NS-1:0] raw_nxt;
    logic [NS-1:0] prev_r;
    logic [NS-1:0] prev_nxt;
    logic [NS-1:0] latch_r;
    logic [NS-1:0] latch_nxt;
    logic [NS-1:0] is_edge;
    logic [NS-1:0] hit;
    logic [NS-1:0] pend;
    logic fast_r;
    logic fast_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [VEC_W-1:0] vec_r;
    logic [VEC_W-1:0] vec_nxt;
    logic [PRIO_W-1:0] prio_r;
    logic [PRIO_W-1:0] prio_nxt;

    // Per-source mode decode; external polarity folded into the sampled level
    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : g_src
            if (g < N_INT)
            begin : g_int
                assign raw_nxt[g] = periph_src_in[g];
                assign is_edge[g] = int_edge_mode_in[g] == INT_MODE_EDGE;
            end
            else
            begin : g_ext
                localparam int E = g - N_INT;
                logic [1:0] md;
                assign md = ext_mode_in[2*E +: 2];
                // Low level and negative edge invert the pin
                assign raw_nxt[g] = ext_request_line_in[E] ^
                    (md == EXT_MODE_LOW_LEVEL || md == EXT_MODE_NEG_EDGE);
                assign is_edge[g] = md == EXT_MODE_POS_EDGE || md == EXT_MODE_NEG_EDGE;
            end
            assign hit[g] = raw_r[g] & ~prev_r[g];
            // Set wins over clear so a coincident edge is not lost
            assign latch_nxt[g] = (is_edge[g] & hit[g]) | (latch_r[g] & ~edge_clear_in[g]);
            assign pend[g] = (is_edge[g] ? latch_r[g] : raw_r[g]) & src_enable_in[g];
        end
    endgenerate

    assign prev_nxt = raw_r;

    always_comb
    begin
        irq_nxt = 1'b0;
        vec_nxt = vec_r;
        prio_nxt = PRIO_LOWEST;
        // Lower index wins a tie, so ascending scan with strict compare
        for (int i = 0; i < NS; i++)
        begin
            if (pend[i] && (!irq_nxt || src_prio_in[PRIO_W*i +: PRIO_W] > prio_nxt))
            begin
                irq_nxt = 1'b1;
                prio_nxt = src_prio_in[PRIO_W*i +: PRIO_W];
                vec_nxt = src_vector_in[VEC_W*i +: VEC_W];
            end
        end
        fast_nxt = ext_fast_request_in & fast_enable_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            raw_r <= '0;
            prev_r <= '0;
            latch_r <= '0;
            fast_r <= 1'b0;
            irq_r <= 1'b0;
            vec_r <= VEC_RESET;
            prio_r <= PRIO_LOWEST;
        end
        else if (ce_in)
        begin
            raw_r <= raw_nxt;
            prev_r <= prev_nxt;
            latch_r <= latch_nxt;
            fast_r <= fast_nxt;
            irq_r <= irq_nxt;
            vec_r <= vec_nxt;
            prio_r <= prio_nxt;
        end
    end

    assign core_fast_request_out = fast_r;
    assign core_normal_request_out = irq_r;
    assign handler_vector_out = vec_r;
    assign active_prio_out = prio_r;
    assign pending_out = latch_r;

    property p_fast_only_pin;
        @(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> core_fast_request_out == $past(ext_fast_request_in & fast_enable_in);
    endproperty
    a_fast_only_pin: assert property (p_fast_only_pin)
        else $error("fast request not from pin");

    property p_masked_quiet;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pend == '0) |=> !core_normal_request_out;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("normal request without source");

    property p_pend_raises;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pend != '0) |=> core_normal_request_out;
    endproperty
    a_pend_raises: assert property (p_pend_raises)
        else $error("pending source not requested");

    property p_prio_max;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pend[0]) |=> active_prio_out >= $past(src_prio_in[PRIO_W-1:0]);
    endproperty
    a_prio_max: assert property (p_prio_max)
        else $error("lower priority won");

    sequence s_ext0_rise;
        ce_in && ext_mode_in[1:0] == EXT_MODE_POS_EDGE && raw_r[N_INT] && !prev_r[N_INT];
    endsequence
    property p_ext_edge_latch;
        @(posedge clk_in) disable iff (!rstn_in)
        s_ext0_rise |=> pending_out[N_INT];
    endproperty
    a_ext_edge_latch: assert property (p_ext_edge_latch)
        else $error("edge not latched");

    property p_int_level_no_latch;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && int_edge_mode_in[0] == INT_MODE_LEVEL && !pending_out[0]) |=> !pending_out[0];
    endproperty
    a_int_level_no_latch: assert property (p_int_level_no_latch)
        else $error("level src latched");

    property p_vector_match;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pend == NS'(1'h1)) |=> handler_vector_out == $past(src_vector_in[VEC_W-1:0]);
    endproperty
    a_vector_match: assert property (p_vector_match)
        else $error("wrong handler vector");

    property p_two_outputs;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !ext_fast_request_in && pend != '0) |=>
            core_normal_request_out && !core_fast_request_out;
    endproperty
    a_two_outputs: assert property (p_two_outputs)
        else $error("requests crossed");

    // Reset must win over a low ce_in, so no disable here
    property p_reset_quiet;
        @(posedge clk_in)
        !rstn_in |=> !core_fast_request_out && !core_normal_request_out &&
            handler_vector_out == VEC_RESET && active_prio_out == PRIO_LOWEST &&
            pending_out == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");

    property p_ce_freeze;
        @(posedge clk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(core_fast_request_out) && $stable(core_normal_request_out) &&
            $stable(handler_vector_out) && $stable(active_prio_out) && $stable(pending_out);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved with clock enable low");

    property p_fast_masked;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !fast_enable_in) |=> !core_fast_request_out;
    endproperty
    a_fast_masked: assert property (p_fast_masked)
        else $error("masked fast request reached core");

    // A clear in the cycle of a new edge must not lose that edge
    sequence s_int0_edge_with_clear;
        ce_in && is_edge[0] && hit[0] && edge_clear_in[0];
    endsequence
    property p_set_beats_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        s_int0_edge_with_clear |=> pending_out[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("edge lost to coincident clear");

    sequence s_pair_tie;
        ce_in && pend[1:0] == 2'h3 && pend[NS-1:2] == '0 &&
            src_prio_in[PRIO_W-1:0] == src_prio_in[2*PRIO_W-1:PRIO_W];
    endsequence
    property p_tie_low_index;
        @(posedge clk_in) disable iff (!rstn_in)
        s_pair_tie |=> handler_vector_out == $past(src_vector_in[VEC_W-1:0]);
    endproperty
    a_tie_low_index: assert property (p_tie_low_index)
        else $error("tie not won by lower index");

    // Vector holds when idle so software can still read the last winner
    property p_idle_holds_vector;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pend == '0) |=>
            active_prio_out == PRIO_LOWEST && $stable(handler_vector_out);
    endproperty
    a_idle_holds_vector: assert property (p_idle_holds_vector)
        else $error("idle vector or priority moved");
endmodule : vectored_irq_unit
`default_nettype wire

/* File: src/vectored_irq_pkg.sv */
// Constants shared by the vectored interrupt controller
package vectored_irq_pkg;
    localparam int NUM_INT_SRC = 8;
    localparam int NUM_EXT_SRC = 4;
    localparam int NUM_SRC = NUM_INT_SRC + NUM_EXT_SRC;
    localparam int PRIO_W = 3;
    localparam int VEC_W = 32;
    localparam logic [PRIO_W-1:0] PRIO_LOWEST = 3'h0;
    localparam logic [VEC_W-1:0] VEC_RESET = 32'h00000000;
    localparam logic INT_MODE_LEVEL = 1'h0;
    localparam logic INT_MODE_EDGE = 1'h1;
    localparam logic [1:0] EXT_MODE_LOW_LEVEL = 2'h0;
    localparam logic [1:0] EXT_MODE_NEG_EDGE = 2'h1;
    localparam logic [1:0] EXT_MODE_HIGH_LEVEL = 2'h2;
    localparam logic [1:0] EXT_MODE_POS_EDGE = 2'h3;
endpackage : vectored_irq_pkg

/* File: tb/irq_source_model.sv */
// Peripheral interrupt source model
`timescale 1ns/1ns
`default_nettype none
module irq_source_model
    import vectored_irq_pkg::*;
(
    input wire logic [2*NUM_INT_SRC-1:0] status_in,
    input wire logic [2*NUM_INT_SRC-1:0] mask_in,
    output logic [NUM_INT_SRC-1:0] src_out
);
    // Two status bits per peripheral, so the OR really merges
    always_comb
    begin
        for (int i = 0; i < NUM_INT_SRC; i++)
            src_out[i] = |(status_in[2*i +: 2] & mask_in[2*i +: 2]);
    end
endmodule : irq_source_model
`default_nettype wire

/* File: tb/vectored_irq_unit_bench.sv */
// Bench for the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
module vectored_irq_unit_bench
    import vectored_irq_pkg::*;
;
    logic clk_in = 0, rstn_in = 0, fastr = 0, fen = 0, ce = 1;
    logic [15:0] st = 0, mk = 16'hFFFF;
    logic [7:0] per, iem = 0, emode = 0;
    logic [3:0] ext = 0;
    logic [11:0] en = 12'hFFF, clr = 0, pend;
    logic [35:0] prio = 0;
    logic [383:0] vec;
    logic fo, no;
    logic [31:0] hv;
    logic [2:0] ap;
    int num_errors = 0, tests_run = 0;
    initial forever #5 clk_in = ~clk_in;
    initial for (int i = 0; i < 12; i++) vec[32*i +: 32] = 32'h100 + i;
    irq_source_model i_src (.status_in(st), .mask_in(mk), .src_out(per));
    vectored_irq_unit i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .periph_src_in(per), .ext_request_line_in(ext), .ext_fast_request_in(fastr),
        .fast_enable_in(fen), .int_edge_mode_in(iem), .ext_mode_in(emode),
        .src_enable_in(en), .src_prio_in(prio), .src_vector_in(vec), .edge_clear_in(clr),
        .core_fast_request_out(fo), .core_normal_request_out(no),
        .handler_vector_out(hv), .active_prio_out(ap), .pending_out(pend));
    task step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task t_prio();
        fastr = 1; fen = 1; step(3);
        check("fast", fo, 1);
        fastr = 0; st = 16'h0009; prio[2:0] = 2; prio[5:3] = 5; step(4);
        check("fast_periph", fo, 0);
        check("normal", no, 1);
        check("vector", hv, 32'h101);
        check("prio", ap, 5);
        en[1] = 0; step(4);
        check("masked_vec", hv, 32'h100);
        st = 0; en = 12'h100; $display("Priority test done");
    endtask : t_prio
    task t_ext();
        for (int m = 0; m < 4; m++)
        begin
            emode = 8'(m); ext[0] = ~m[1]; step(4);
            clr[8] = 1; step(1); clr[8] = 0; step(3);
            check("ext_idle", no, 0);
            ext[0] = m[1]; step(5);
            check("ext_active", no, 1);
            if (m[0]) check("ext_latch", pend[8], 1);
        end
        clr[8] = 1; emode = 8'h02; ext = 0; step(2); clr[8] = 0;
        $display("External mode test done");
    endtask : t_ext
    task t_int_edge();
        iem[2] = 1; en = 12'h004; st[4] = 1; step(1); st[4] = 0; step(5);
        check("int_latch", pend[2], 1);
        check("int_req", no, 1);
        clr[2] = 1; step(1); clr[2] = 0; step(3);
        check("int_clear", no, 0);
        iem = 8'h01;
        en = 12'h001;
        clr[0] = 1;
        st[0] = 1;
        step(2);
        clr[0] = 0;
        st[0] = 0;
        step(3);
        check("clear_race_latch", pend[0], 1);
        check("clear_race_req", no, 1);
        clr[0] = 1;
        step(1);
        clr[0] = 0;
        iem = 0;
        step(2);
        $display("Internal edge test done");
    endtask : t_int_edge
    task t_misc();
        en = 12'h003;
        st = 16'h0005;
        prio[5:0] = 6'h24;
        step(3);
        check("tie_vec", hv, 32'h100);
        check("tie_prio", ap, 4);
        fastr = 1;
        fen = 0;
        step(3);
        check("fast_masked", fo, 0);
        fen = 1;
        step(1);
        check("fast_on", fo, 1);
        ce = 0;
        fastr = 0;
        st = 0;
        step(4);
        check("freeze_fast", fo, 1);
        check("freeze_normal", no, 1);
        ce = 1;
        step(3);
        check("idle_fast", fo, 0);
        check("idle_normal", no, 0);
        check("idle_prio", ap, 0);
        check("idle_vec", hv, 32'h100);
        st = 16'h0001;
        step(3);
        rstn_in = 0;
        step(2);
        check("rst_normal", no, 0);
        check("rst_vec", hv, 32'h0);
        check("rst_prio", ap, 0);
        check("rst_pend", pend, 0);
        rstn_in = 1;
        step(1);
        check("rel_normal", no, 0);
        step(1);
        check("rel_request", no, 1);
        check("rel_vec", hv, 32'h100);
        st = 0;
        step(2);
        $display("Control test done");
    endtask : t_misc
    initial
    begin
        step(5);
        rstn_in = 1;
        t_prio();
        t_ext();
        t_int_edge();
        t_misc();
        complete_run();
    end
    initial
    begin
        #20000;
        num_errors++;
        complete_run();
    end
endmodule : vectored_irq_unit_bench
`default_nettype wire
